// ==== ucr_pkg.sv ====
// Package with timing constants, states and transmit levels for the unblock channel receiver
package ucr_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned LOB_WINDOW_MS   = 150;
  localparam int unsigned CHFAIL_MS       = 150;
  localparam int unsigned OPEN_BRK_MS     = 1000;
  localparam int unsigned NS_PER_MS       = 1000000;
  localparam int unsigned LOB_CYCLES      = LOB_WINDOW_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned CHFAIL_CYCLES   = CHFAIL_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned OPEN_BRK_CYCLES = OPEN_BRK_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned CNT_W           = 27;
  localparam int unsigned LOW_POWER_W     = 1;
  localparam int unsigned BOOST_POWER_W   = 10;

  typedef enum logic [1:0] {
    UCR_NORMAL  = 2'h0,
    UCR_WINDOW  = 2'h1,
    UCR_LOCKOUT = 2'h3,
    UCR_CHFAIL  = 2'h2
  } ucr_state_t;
endpackage

// ==== ucr_sync.sv ====
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module ucr_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } ucr_sync_st_t;

  ucr_sync_st_t s_q;
  ucr_sync_st_t s_d;

  initial begin
    if (WIDTH < 1) $error("ucr_sync: WIDTH must be positive");
  end

  always_comb begin
    s_d      = s_q;
    s_d.meta = async_i;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.sync;
endmodule

// ==== ucr_receiver.sv ====
// Directional comparison unblock receiver logic with transmitter keying
`timescale 1ns/100ps
module ucr_receiver
  import ucr_pkg::*;
#(
  parameter int unsigned LOB_CNT      = ucr_pkg::LOB_CYCLES,
  parameter int unsigned CHFAIL_CNT   = ucr_pkg::CHFAIL_CYCLES,
  parameter int unsigned OPEN_BRK_CNT = ucr_pkg::OPEN_BRK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic block_det_i,
  input  wire logic unblock_det_i,
  input  wire logic remote_trip_i,
  input  wire logic local_fault_i,
  input  wire logic internal_fault_i,
  output logic      trip_permit_relay_o,
  output logic      loss_of_block_o,
  output logic      channel_alarm_o,
  output logic      lockout_o,
  output logic      remote_open_o,
  output logic      key_unblock_o,
  output logic      power_boost_o
);
  import ucr_pkg::*;

  typedef struct packed {
    ucr_state_t       state;
    logic [CNT_W-1:0] lob_cnt;
    logic [CNT_W-1:0] chf_cnt;
    logic [CNT_W-1:0] rt_cnt;
    logic             permit;
    logic             lob;
    logic             alarm;
    logic             lockout;
    logic             remote_open;
    logic             key_ub;
    logic             boost;
  } ucr_st_t;

  ucr_st_t s_q;
  ucr_st_t s_d;

  logic [3:0] pins_s;
  logic       blk;
  logic       ubk;
  logic       rtr;
  logic       ifl;

  initial begin
    if (LOB_CNT < 1 || LOB_CNT >= (1 << CNT_W)) $error("ucr_receiver: LOB_CNT out of range");
    if (CHFAIL_CNT < 1 || CHFAIL_CNT >= (1 << CNT_W)) $error("ucr_receiver: CHFAIL_CNT out of range");
    if (OPEN_BRK_CNT < 1 || OPEN_BRK_CNT >= (1 << CNT_W)) $error("ucr_receiver: OPEN_BRK_CNT out of range");
  end

  // Receiver detections and relay contacts arrive from outside the clock domain
  ucr_sync #(.WIDTH(4)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({block_det_i, unblock_det_i, remote_trip_i, internal_fault_i}),
    .sync_o  (pins_s)
  );
  assign blk = pins_s[3];
  assign ubk = pins_s[2];
  assign rtr = pins_s[1];
  assign ifl = pins_s[0];

  // Local fault is taken as same-domain relay logic
  always_comb begin
    s_d = s_q;
    s_d.key_ub = ifl;
    s_d.boost  = ifl;
    // Remote trip counts on its own input; qualifying it by unblock would hide the fault path
    if (rtr) begin
      if (s_q.rt_cnt < CNT_W'(OPEN_BRK_CNT)) s_d.rt_cnt = s_q.rt_cnt + 1'b1;
    end else begin
      s_d.rt_cnt = '0;
    end
    s_d.remote_open = (s_d.rt_cnt >= CNT_W'(OPEN_BRK_CNT));
    // Channel failure timer runs only when neither frequency is heard
    if (!blk && !ubk) begin
      if (s_q.chf_cnt < CNT_W'(CHFAIL_CNT)) s_d.chf_cnt = s_q.chf_cnt + 1'b1;
    end else begin
      s_d.chf_cnt = '0;
    end
    case (s_q.state)
      UCR_NORMAL: begin
        s_d.lob_cnt = '0;
        if (!blk && !ubk) begin
          s_d.state   = UCR_WINDOW;
          s_d.lob_cnt = CNT_W'(1);
        end
      end
      UCR_WINDOW: begin
        if (blk || ubk) begin
          s_d.state = UCR_NORMAL;
        end else if (s_q.lob_cnt >= CNT_W'(LOB_CNT)) begin
          s_d.state = UCR_LOCKOUT;
        end else begin
          s_d.lob_cnt = s_q.lob_cnt + 1'b1;
        end
      end
      UCR_LOCKOUT: begin
        if (blk) s_d.state = UCR_NORMAL;
        else if (s_d.chf_cnt >= CNT_W'(CHFAIL_CNT)) s_d.state = UCR_CHFAIL;
      end
      UCR_CHFAIL: begin
        if (blk) s_d.state = UCR_NORMAL;
      end
      default: s_d.state = UCR_NORMAL;
    endcase
    // A sustained silent channel also locks out from the window
    if (s_d.state == UCR_WINDOW && s_d.chf_cnt >= CNT_W'(CHFAIL_CNT)) s_d.state = UCR_CHFAIL;
    s_d.lob     = (s_d.state == UCR_WINDOW);
    s_d.lockout = (s_d.state == UCR_LOCKOUT) || (s_d.state == UCR_CHFAIL);
    s_d.alarm   = (s_d.state == UCR_CHFAIL);
    // Unblock bypasses the timing path; open breaker needs a local fault
    s_d.permit  = ubk || s_d.lob || (s_d.remote_open && local_fault_i);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign trip_permit_relay_o = s_q.permit;
  assign loss_of_block_o     = s_q.lob;
  assign channel_alarm_o     = s_q.alarm;
  assign lockout_o           = s_q.lockout;
  assign remote_open_o       = s_q.remote_open;
  assign key_unblock_o       = s_q.key_ub;
  assign power_boost_o       = s_q.boost;

  a_block_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    blk && !ubk && !rtr |=> !s_q.permit ##0 !s_q.lob)
    else $error("Permit active while block received");
  a_lob_start: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.state == UCR_NORMAL && !blk && !ubk |=> s_q.permit && s_q.lob)
    else $error("Loss of block did not open window");
  a_lob_end: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.state == UCR_WINDOW && !blk && !ubk && s_q.lob_cnt >= CNT_W'(LOB_CNT) |=> s_q.lockout)
    else $error("Window did not end in lockout");
  a_unblock_permit: assert property (@(posedge clk_i) disable iff (reset_i)
    ubk |=> s_q.permit)
    else $error("Unblock did not permit trip");
  a_unblock_halts: assert property (@(posedge clk_i) disable iff (reset_i)
    ubk |=> s_q.chf_cnt == '0)
    else $error("Unblock did not halt failure timer");
  a_chfail_alarm: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(s_q.alarm) |-> s_q.lockout && !$past(blk) && !s_q.lob)
    else $error("Alarm raised without channel failure");
  a_remote_open: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.remote_open && $past(local_fault_i) |-> s_q.permit)
    else $error("Open breaker did not permit trip");
  a_key_follow: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.key_ub == $past(ifl) && s_q.boost == s_q.key_ub)
    else $error("Keying does not follow internal fault");
  a_restore: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.lockout && blk |=> !s_q.lockout ##0 !s_q.alarm)
    else $error("Block return did not clear lockout");

  // Lockout, alarm and permit cause checks
  a_lockout_denies: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.lockout && !blk && !ubk && !rtr |=> !s_q.permit)
    else $error("Permit active in lockout");
  a_lockout_no_window: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.lockout |-> !s_q.lob)
    else $error("Window active in lockout");
  a_alarm_locked: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.alarm |-> s_q.lockout)
    else $error("Alarm without lockout");
  a_alarm_set: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.state == UCR_LOCKOUT && !blk && !ubk && s_q.chf_cnt == CNT_W'(CHFAIL_CNT - 1) |=> s_q.alarm)
    else $error("Silent channel did not raise alarm");
  a_alarm_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.alarm && !blk |=> s_q.alarm)
    else $error("Alarm dropped without block return");
  a_unblock_nolock: assert property (@(posedge clk_i) disable iff (reset_i)
    ubk && !s_q.lockout |=> !s_q.lockout)
    else $error("Unblock led to lockout");
  a_permit_cause: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.permit |-> $past(ubk) || s_q.lob || s_q.remote_open)
    else $error("Permit without a cause");

  // Remote breaker, keying, window bound and normal state checks
  a_open_set: assert property (@(posedge clk_i) disable iff (reset_i)
    rtr && s_q.rt_cnt == CNT_W'(OPEN_BRK_CNT - 1) |=> s_q.remote_open)
    else $error("Sustained remote trip not seen as open");
  a_open_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    !rtr |=> !s_q.remote_open)
    else $error("Open breaker held without remote trip");
  a_boost_release: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(ifl) |-> !s_q.boost)
    else $error("Boost active while sending block");
  a_window_bound: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.lob |-> s_q.lob_cnt <= CNT_W'(LOB_CNT) && s_q.lob_cnt != '0)
    else $error("Window count out of range");
  a_normal_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.state == UCR_NORMAL |-> !s_q.lockout && !s_q.alarm && !s_q.lob)
    else $error("Normal state shows window or lockout");

  c_window: cover property (@(posedge clk_i) disable iff (reset_i) $rose(s_q.lob));
  c_lockout: cover property (@(posedge clk_i) disable iff (reset_i) $rose(s_q.lockout));
  c_alarm: cover property (@(posedge clk_i) disable iff (reset_i) $rose(s_q.alarm));
  c_open: cover property (@(posedge clk_i) disable iff (reset_i) $rose(s_q.remote_open));
  c_unblock: cover property (@(posedge clk_i) disable iff (reset_i) ubk && s_q.permit);
endmodule

// ==== ucr_far_model.sv ====
// Far-end carrier terminal model driving frequency detections
`timescale 1ns/100ps
module ucr_far_model (
  input  wire logic [1:0] mode_i,
  output logic            block_det_o,
  output logic            unblock_det_o
);
  // Mode 0 block, 1 silent channel, 2 unblock keyed; never both tones at once
  assign block_det_o   = (mode_i == 2'h0);
  assign unblock_det_o = (mode_i == 2'h2);
endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the unblock channel receiver
`timescale 1ns/100ps
module tb_top;
  import ucr_pkg::*;
  logic       clk_i;
  logic       reset_i;
  logic [1:0] mode;
  logic       blk;
  logic       ublk;
  logic       rtrip;
  logic       lfault;
  logic       ifault;
  logic       permit;
  logic       lob;
  logic       alarm;
  logic       lock;
  logic       ropen;
  logic       key;
  logic       boost;
  int         failures;
  int         n_compared;
  int         cycles;
  ucr_far_model far (.mode_i(mode), .block_det_o(blk), .unblock_det_o(ublk));
  // Short counts keep the run brief; expectations follow these values
  ucr_receiver #(.LOB_CNT(20), .CHFAIL_CNT(30), .OPEN_BRK_CNT(50)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .block_det_i(blk), .unblock_det_i(ublk),
    .remote_trip_i(rtrip), .local_fault_i(lfault), .internal_fault_i(ifault),
    .trip_permit_relay_o(permit), .loss_of_block_o(lob), .channel_alarm_o(alarm),
    .lockout_o(lock), .remote_open_o(ropen), .key_unblock_o(key), .power_boost_o(boost));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_normal();
    mode = 2'h0;
    wt(8);
    chk(permit, 1'b0);
    chk(lob, 1'b0);
    chk(key, 1'b0);
    chk(boost, 1'b0);
  endtask
  task automatic t_loss();
    mode = 2'h1;
    wt(6);
    chk(lob, 1'b1);
    chk(permit, 1'b1);
    wt(20);
    chk(lock, 1'b1);
    chk(permit, 1'b0);
    wt(10);
    chk(alarm, 1'b1);
    mode = 2'h0;
    wt(6);
    chk(lock, 1'b0);
    chk(alarm, 1'b0);
  endtask
  task automatic t_unblock();
    mode = 2'h2;
    rtrip = 1'b1;
    wt(70);
    chk(permit, 1'b1);
    chk(lock, 1'b0);
    chk(alarm, 1'b0);
    chk(ropen, 1'b1);
    mode = 2'h0;
    rtrip = 1'b0;
    wt(8);
  endtask
  task automatic t_key();
    ifault = 1'b1;
    wt(6);
    chk(key, 1'b1);
    chk(boost, 1'b1);
    ifault = 1'b0;
    wt(6);
    chk(boost, 1'b0);
    chk(key, 1'b0);
  endtask
  task automatic t_open();
    mode = 2'h0;
    rtrip = 1'b1;
    lfault = 1'b1;
    wt(56);
    chk(ropen, 1'b1);
    chk(permit, 1'b1);
    lfault = 1'b0;
    wt(2);
    chk(permit, 1'b0);
    rtrip = 1'b0;
    wt(6);
    chk(ropen, 1'b0);
  endtask
  // Hang guard: whole sequence needs well under this many cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    failures = 0;
    n_compared = 0;
    cycles = 0;
    reset_i = 1'b1;
    mode = 2'h0;
    rtrip = 1'b0;
    lfault = 1'b0;
    ifault = 1'b0;
    wt(4);
    reset_i = 1'b0;
    t_normal();
    t_loss();
    t_unblock();
    t_open();
    t_key();
    print_verdict();
  end
endmodule
